//--- core/bpi_loader.sv
// Purpose: loads configuration bytes from a parallel NOR flash
// Assumes: flash answers within one config clock period
// Notes: last byte of the frame is a checksum over the others
`timescale 1ns/10ps
`include "bpi_loader_defs.svh"

// Operation
// - Parallel flash mode only when mode pins read 0,1,0 or 0,1,1.
// - Drive up to 24 address bits; reduced variant keeps only 20.
// - Bytes only; flash used in 8-bit mode, x16-only unsupported.
// - Direction pin low: start at zero, increment each falling clock while the FIFO has room.
// - Direction pin high: start all ones, decrement each falling clock while the FIFO has room.
// - Mode pins sampled as init indicator rises; outside holds them valid.
// - Pull-ups on during configuration when pull-up control is low.
// - Flash chip enable driven low throughout configuration.
// - Flash output enable driven low throughout configuration.
// - Flash write enable driven high throughout configuration.
// - Byte mode low while configuring; user logic may drive it after.
// - Chip select out, config clock and busy actively driven when configuring.
// - After done, interface pins become user I/O; mode pins released.
// - Keep-port option keeps parallel slave port active after configuration.
// - Shared flash: only one party boots; program input holds device off.
// - New address on falling clock edge, byte captured from data input.
// - Checksum error pulls init indicator low.
// - Done low while configuring, high only after success.
module bpi_loader #(
   parameter bit NARROW_ADDR = 1'b0,
   parameter logic [23:0] FRAME_LEN = `FRAME_LEN_DEF
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_program_request_n,
   input wire logic [2:0] i_mode,
   input wire logic i_pullup_disable_input,
   input wire logic i_chip_select_in_n,
   input wire logic i_read_write_control_n,
   input wire logic i_keep_port,
   input wire logic i_init_in,
   input wire logic [7:0] i_flash_data,
   input wire logic i_user_byte_mode,
   output bpi_loader_pkg::flash_ctl_t o_flash,
   output logic o_flash_drive,
   output logic o_chip_select_out_n,
   output logic o_config_clock_out,
   output logic o_busy,
   output logic o_init_out,
   output logic o_init_oe_n,
   output logic o_done_oe_n,
   output logic o_pullups_en,
   output logic o_user_io,
   output logic o_port_active,
   output logic o_cfg_valid,
   input wire logic i_cfg_ready,
   output logic [7:0] o_cfg_data
);
   import bpi_loader_pkg::*;

   ////////////////////////////////////////////////////////////////////
   load_state_t state_r;
   load_state_t state_nxt;
   logic [23:0] addr_r;
   logic dir_r;
   logic [3:0] div_r;
   logic config_clock_out_r;
   logic [23:0] left_r;
   logic [7:0] sum_r;
   logic keep_r;
   logic fifo_ready;
   logic in_valid_r;
   logic [7:0] in_data_r;

   // Mode pin decode
   function automatic logic is_bpi(input logic [2:0] m);
      return m[2:1] == `MODE_HI2;
   endfunction

   wire mode_ok = is_bpi(i_mode);
   wire init_rise = state_r == ST_INIT && i_init_in;
   wire config_clock_out_fall = div_r == `CONFIG_CLOCK_OUT_DIV && config_clock_out_r;
   wire fetching = state_r == ST_READ;
   wire last_byte = left_r == `LEFT_LAST;
   wire step = fetching && config_clock_out_fall && fifo_ready;
   wire configuring = state_r == ST_READ || state_r == ST_CHECK || state_r == ST_INIT;
   wire [23:0] addr_next = dir_r ? addr_r - `ADDR_STEP : addr_r + `ADDR_STEP;
   wire [23:0] addr_mask;

   // Reduced variant keeps only the low address lines
   for (genvar b = 0; b < 24; b++) begin : g_addr_mask
      assign addr_mask[b] = !NARROW_ADDR || (b < `NARROW_W);
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            state_nxt = ST_INIT;
         end
         ST_INIT: begin
            // Mode latched as init indicator rises
            if (init_rise) state_nxt = mode_ok ? ST_READ : ST_ERR;
         end
         ST_READ: begin
            if (step && last_byte) state_nxt = ST_CHECK;
         end
         ST_CHECK: begin
            state_nxt = (sum_r == `CRC_SEED) ? ST_DONE : ST_ERR;
         end
         ST_DONE: begin
            state_nxt = ST_DONE;
         end
         ST_ERR: begin
            state_nxt = ST_ERR;
         end
      endcase
   end

   // Program input returns the state machine to idle
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= ST_IDLE;
      end else if (!i_program_request_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Config clock from divider, runs while configuring
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_r <= `DIV_START;
         config_clock_out_r <= 1'b0;
      end else if (div_r == `CONFIG_CLOCK_OUT_DIV) begin
         div_r <= `DIV_START;
         config_clock_out_r <= ~config_clock_out_r;
      end else begin
         div_r <= div_r + `DIV_INC;
      end
   end

   // Address counter
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_r <= `ADDR_START_UP;
         dir_r <= 1'b0;
         left_r <= `COUNT_ZERO;
         keep_r <= 1'b0;
      end else if (init_rise) begin
         dir_r <= i_mode[0];
         addr_r <= i_mode[0] ? `ADDR_START_DN : `ADDR_START_UP;
         left_r <= FRAME_LEN;
         keep_r <= i_keep_port;
      end else if (step) begin
         addr_r <= addr_next;
         left_r <= left_r - `ADDR_STEP;
      end
   end

   // Byte capture and running checksum
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         in_valid_r <= 1'b0;
         in_data_r <= 8'h00;
         sum_r <= `CRC_SEED;
      end else begin
         in_valid_r <= step && !last_byte;
         if (step) in_data_r <= i_flash_data;
         if (init_rise) sum_r <= `CRC_SEED;
         else if (step) sum_r <= sum_r + i_flash_data;
      end
   end

   byte_fifo #(
      .WIDTH(8),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_in_valid(in_valid_r),
      .o_in_ready(fifo_ready),
      .i_in_data(in_data_r),
      .o_out_valid(o_cfg_valid),
      .i_out_ready(i_cfg_ready),
      .o_out_data(o_cfg_data)
   );

   ////////////////////////////////////////////////////////////////////
   // Flash controls fixed while configuring
   assign o_flash.addr = addr_r & addr_mask;
   assign o_flash.ce_n = 1'b0;
   assign o_flash.oe_n = 1'b0;
   assign o_flash.we = 1'b1;
   assign o_flash.byte_n = configuring ? 1'b0 : i_user_byte_mode;
   assign o_flash_drive = fetching || state_r == ST_CHECK;
   assign o_chip_select_out_n = 1'b1;
   assign o_config_clock_out = config_clock_out_r;
   assign o_busy = 1'b0;
   // Open drain indicators, enable low drives the pin low
   assign o_init_out = 1'b0;
   assign o_init_oe_n = !(state_r == ST_IDLE || state_r == ST_ERR);
   assign o_done_oe_n = state_r == ST_DONE;
   assign o_pullups_en = configuring && !i_pullup_disable_input;
   assign o_user_io = state_r == ST_DONE;
   assign o_port_active = state_r == ST_DONE && keep_r;

   ////////////////////////////////////////////////////////////////////
   // Assertion helper: bytes fetched since the last init rise
   logic [23:0] fetched_r;
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fetched_r <= `COUNT_ZERO;
      end else if (init_rise) begin
         fetched_r <= `COUNT_ZERO;
      end else if (step) begin
         fetched_r <= fetched_r + `ADDR_STEP;
      end
   end

   a_fetch_needs_init: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $rose(fetching) |-> $past(i_init_in) && $past(state_r) == ST_INIT)
      else $error("fetch began without init release");
   a_init_no_drive: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_INIT |-> !o_flash_drive)
      else $error("flash driven before init release");
   a_mode_gate: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      init_rise && !mode_ok && i_program_request_n |=> state_r == ST_ERR)
      else $error("bad mode not refused");
   a_mode_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      init_rise |=> dir_r == $past(i_mode[0]) && keep_r == $past(i_keep_port))
      else $error("mode pins not latched at init rise");
   a_up_start: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      init_rise && i_program_request_n && !i_mode[0] |=> addr_r == 24'h000000)
      else $error("up start wrong");
   a_down_start: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      init_rise && i_program_request_n && i_mode[0] |=> addr_r == 24'hFFFFFF)
      else $error("down start wrong");
   a_addr_step: assert property (@(posedge i_mclk)
      disable iff (!i_rst_b)
      step && !init_rise |=> addr_r == ($past(dir_r) ? $past(addr_r) - 24'h000001
                                         : $past(addr_r) + 24'h000001))
      else $error("address step wrong");
   a_step_on_fall: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      step |=> $fell(o_config_clock_out))
      else $error("address moved off falling edge");
   a_step_spacing: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      step |=> !step [*7])
      else $error("two fetches within one clock period");
   a_push_byte: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      step |=> in_valid_r == !$past(last_byte))
      else $error("fetched byte not handed on");
   a_frame_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      $rose(state_r == ST_CHECK) |-> fetched_r == FRAME_LEN)
      else $error("frame length wrong at check");
   a_ctl_levels: assert property (@(posedge i_mclk)
      disable iff (!i_rst_b)
      configuring |-> !o_flash.ce_n && !o_flash.oe_n && o_flash.we && !o_flash.byte_n)
      else $error("flash control level wrong");
   a_byte_user: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      !configuring |-> o_flash.byte_n == i_user_byte_mode)
      else $error("byte mode not handed to user");
   a_idle_pins: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      configuring |-> o_chip_select_out_n && !o_busy)
      else $error("unused outputs not driven");
   a_config_clock_out_runs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      div_r == `CONFIG_CLOCK_OUT_DIV |=> o_config_clock_out != $past(o_config_clock_out))
      else $error("config clock stopped");
   a_narrow_addr: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      NARROW_ADDR |-> o_flash.addr[23:20] == 4'h0)
      else $error("upper address lines on reduced variant");
   a_crc_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_CHECK && sum_r != 8'h00 && i_program_request_n |=> !o_init_oe_n)
      else $error("checksum error not flagged");
   a_err_holds_init: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_ERR |-> !o_init_oe_n)
      else $error("init released after error");
   a_done_level: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      configuring |-> !o_done_oe_n)
      else $error("done released early");
   a_done_on_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_CHECK && sum_r == `CRC_SEED && i_program_request_n |=> o_done_oe_n)
      else $error("done not released after good frame");
   a_user_after_done: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_user_io |-> o_done_oe_n)
      else $error("user io before done");
   a_port_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      o_port_active |-> o_user_io && keep_r)
      else $error("parallel port kept without option");
   a_pullup_ctl: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      configuring |-> o_pullups_en == !i_pullup_disable_input)
      else $error("pull-up control wrong");
   c_load_ok: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_CHECK ##1 state_r == ST_DONE);
   c_load_bad: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
      state_r == ST_CHECK ##1 state_r == ST_ERR);
   c_down_fetch: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
      step && dir_r);
   c_up_fetch: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
      step && !dir_r);
   c_stall: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
      fetching && !fifo_ready);
endmodule

//--- core/bpi_loader_defs.svh
// Purpose: constants for the parallel flash configuration loader
// Assumes: 40 MHz i_mclk
// Notes: definitions only
`ifndef BPI_LOADER_DEFS_SVH
`define BPI_LOADER_DEFS_SVH
`define MODE_HI2 2'h1
`define ADDR_W 24
`define ADDR_START_UP 24'h000000
`define ADDR_START_DN 24'hFFFFFF
`define ADDR_STEP 24'h000001
`define CONFIG_CLOCK_OUT_DIV 4'h3
`define CRC_W 8
`define FIFO_DEPTH 8
`define FRAME_LEN_DEF 24'h000040
`define CRC_SEED 8'h00
`define NARROW_W 20
`define LEFT_LAST 24'h000001
`define COUNT_ZERO 24'h000000
`define DIV_START 4'h0
`define DIV_INC 4'h1
`endif

//--- core/bpi_loader_pkg.sv
// Purpose: types for the parallel flash configuration loader
// Assumes: nothing
// Notes: flash pin group and loader states
package bpi_loader_pkg;
   typedef struct packed {
      logic [23:0] addr;
      logic ce_n;
      logic oe_n;
      logic we;
      logic byte_n;
   } flash_ctl_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_INIT = 6'h02,
      ST_READ = 6'h04,
      ST_CHECK = 6'h08,
      ST_DONE = 6'h10,
      ST_ERR = 6'h20
   } load_state_t;
endpackage

//--- core/byte_fifo.sv
// Purpose: small FIFO between flash reader and configuration sink
// Assumes: single clock
// Notes: read data registered
`timescale 1ns/10ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic [AW:0] cnt_r;
   logic [WIDTH-1:0] dout_r;
   logic dv_r;
   wire full = cnt_r == (AW+1)'(DEPTH);
   wire empty = cnt_r == '0;
   wire push = i_in_valid && !full;
   wire take = !empty && (!dv_r || i_out_ready);
   assign o_in_ready = !full;
   assign o_out_valid = dv_r;
   assign o_out_data = dout_r;
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= i_in_data;
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         dout_r <= '0;
         dv_r <= 1'b0;
      end else begin
         if (push) wp_r <= wp_r + 1'b1;
         if (take) begin
            rp_r <= rp_r + 1'b1;
            dout_r <= mem_r[rp_r[AW-1:0]];
            dv_r <= 1'b1;
         end else if (i_out_ready) begin
            dv_r <= 1'b0;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(take);
      end
   end
endmodule

//--- test/flash_model.sv
// Purpose: byte-wide NOR flash holding one configuration frame
// Assumes: frame of N bytes, last is the checksum
// Notes: read data follows the address one mclk later
`timescale 1ns/10ps
module flash_model #(
   parameter int N = 12
) (
   input wire logic i_mclk,
   input wire bpi_loader_pkg::flash_ctl_t i_flash,
   input wire logic i_down,
   input wire logic i_bad,
   output logic [7:0] o_data
);
   import bpi_loader_pkg::*;
   logic [23:0] idx;
   logic [7:0] sum_b;
   // Frame position counted from whichever end is read
   assign idx = i_down ? 24'hFFFFFF - i_flash.addr : i_flash.addr;
   assign sum_b = 8'(0 - (N - 1) * N / 2) ^ {7'h00, i_bad};
   always_ff @(posedge i_mclk) begin
      if (i_flash.ce_n | i_flash.oe_n | !i_flash.we) begin
         o_data <= ~o_data;
      end else if (idx < 24'(N - 1)) begin
         o_data <= 8'(idx + 24'h1);
      end else begin
         o_data <= sum_b;
      end
   end
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the parallel flash loader
// Assumes: frame shortened to 12 bytes
// Notes: init wire is open drain, modelled below
`timescale 1ns/10ps
module tb_top;
   import bpi_loader_pkg::*;
   logic i_mclk, i_rst_b, prog_n, init_rel, pd, keep, rdy, down, bad, cvalid, ubm;
   logic cso_n, config_clock_out, busy, init_oe_n, done_oe_n, pu, uio, port, drive, init_o;
   logic [2:0] mode;
   logic [7:0] fdata, cdata;
   logic [23:0] a;
   flash_ctl_t fl;
   int fail_count = 0;
   int n_checks = 0;
   wire init_wire = init_rel & init_oe_n;
   bpi_loader #(.FRAME_LEN(24'h00000C)) bpi_loader_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_program_request_n(prog_n), .i_mode(mode), .i_pullup_disable_input(pd),
      .i_chip_select_in_n(1'b0), .i_read_write_control_n(1'b0),
      .i_keep_port(keep), .i_init_in(init_wire), .i_flash_data(fdata),
      .i_user_byte_mode(ubm), .o_flash(fl), .o_flash_drive(drive), .o_chip_select_out_n(cso_n),
      .o_config_clock_out(config_clock_out), .o_busy(busy), .o_init_out(init_o), .o_init_oe_n(init_oe_n),
      .o_done_oe_n(done_oe_n), .o_pullups_en(pu), .o_user_io(uio), .o_port_active(port),
      .o_cfg_valid(cvalid), .i_cfg_ready(rdy), .o_cfg_data(cdata));
   flash_model #(.N(12)) flash_model_i (.i_mclk(i_mclk), .i_flash(fl), .i_down(down),
      .i_bad(bad), .o_data(fdata));
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Restart, set pins, release init; ends two cycles after init rise
   task start(input logic [2:0] m, input logic k, input logic p, input logic b);
      @(negedge i_mclk);
      prog_n = 1'b0;
      init_rel = 1'b0;
      mode = m;
      down = m[0];
      keep = k;
      pd = p;
      bad = b;
      repeat (3) @(negedge i_mclk);
      prog_n = 1'b1;
      repeat (3) @(negedge i_mclk);
      check("no early fetch", drive, 24'h0);
      init_rel = 1'b1;
      repeat (2) @(negedge i_mclk);
   endtask
   task ctl_check;
      logic c;
      int tg;
      tg = 0;
      c = config_clock_out;
      repeat (16) begin
         @(negedge i_mclk);
         if (config_clock_out !== c) tg++;
         c = config_clock_out;
      end
      check("config_clock_out toggles", 24'(tg), 24'h000004);
      check("busy", busy, 24'h0);
      check("cso_n", cso_n, 24'h1);
      check("ce_n", fl.ce_n, 24'h0);
      check("oe_n", fl.oe_n, 24'h0);
      check("we", fl.we, 24'h1);
      check("byte_n", fl.byte_n, 24'h0);
      check("pullups", pu, {23'h0, ~pd});
      check("done low", done_oe_n, 24'h0);
      check("user io", uio, 24'h0);
      check("drive", drive, 24'h1);
      check("init out", init_o, 24'h0);
   endtask
   task take(input int n);
      for (int i = 1; i <= n; i++) begin
         int w;
         w = 0;
         @(negedge i_mclk);
         while (cvalid !== 1'b1 && w < 400) begin
            @(negedge i_mclk);
            w++;
         end
         check("cfg valid", cvalid, 24'h1);
         check("cfg byte", cdata, 24'(i));
         rdy = 1'b1;
         @(negedge i_mclk);
         rdy = 1'b0;
      end
   endtask
   task settle;
      int w;
      w = 0;
      while (done_oe_n !== 1'b1 && init_oe_n !== 1'b0 && w < 400) begin
         @(negedge i_mclk);
         w++;
      end
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      fail_count++;
      final_report;
   end
   initial begin
      i_rst_b = 1'b0;
      prog_n = 1'b1;
      init_rel = 1'b0;
      {pd, keep, rdy, down, bad} = 5'h00;
      ubm = 1'b1;
      mode = 3'h2;
      repeat (5) @(negedge i_mclk);
      i_rst_b = 1'b1;
      start(3'h2, 1'b1, 1'b0, 1'b0);
      check("start up", fl.addr, 24'h000000);
      repeat (150) @(negedge i_mclk);
      a = fl.addr;
      ctl_check;
      check("stalled addr", fl.addr, a);
      check("fifo holds", cvalid, 24'h1);
      take(11);
      settle;
      check("done", done_oe_n, 24'h1);
      check("init ok", init_oe_n, 24'h1);
      check("user io", uio, 24'h1);
      check("keep port", port, 24'h1);
      check("byte after", fl.byte_n, 24'h1);
      $display("test 1 done");
      start(3'h3, 1'b0, 1'b1, 1'b0);
      mode = 3'h0;
      ubm = 1'b0;
      check("start down", fl.addr, 24'hFFFFFF);
      ctl_check;
      take(11);
      settle;
      check("done", done_oe_n, 24'h1);
      check("no keep", port, 24'h0);
      check("byte user", fl.byte_n, 24'h0);
      $display("test 2 done");
      start(3'h3, 1'b0, 1'b0, 1'b1);
      take(11);
      settle;
      check("sum error", init_oe_n, 24'h0);
      check("no done", done_oe_n, 24'h0);
      $display("test 3 done");
      for (int k = 0; k < 8; k++) begin
         if (k == 2 || k == 3) continue;
         start(3'(k), 1'b0, 1'b0, 1'b0);
         a = fl.addr;
         repeat (40) @(negedge i_mclk);
         check("bad mode init", init_oe_n, 24'h0);
         check("bad mode addr", fl.addr, a);
         check("bad mode data", cvalid, 24'h0);
         check("bad mode drive", drive, 24'h0);
      end
      $display("test 4 done");
      final_report;
   end
endmodule
